//--- src/flash_ctrl_end.sv
module flash_ctrl_end #(
  parameter int STALL_CYCLES = fsp_pkg::ERASE_CYCLES
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_on_i,
  // core side
  flash_sfr_if.ctrl core,
  // flash array side
  output logic [fsp_pkg::ADDR_W-1:0] flash_addr_o,
  output logic flash_cfg_space_o,
  output logic flash_rd_o,
  input wire logic [fsp_pkg::DATA_W-1:0] flash_rdata_i,
  output logic [fsp_pkg::ROW_W-1:0] flash_row_o,
  output logic flash_erase_o,
  output logic [fsp_pkg::DATA_W-1:0] flash_wdata_o,
  output logic flash_load_o,
  output logic flash_prog_o,
  // status
  output logic exec_stall_o
);
  import fsp_pkg::*;

  seq_state_t state_q;
  seq_state_t state_d;
  key_stage_t key_q;
  logic [7:0] addr_low_q;
  logic [6:0] addr_high_q;
  logic [7:0] data_low_q;
  logic [5:0] data_high_q;
  logic read_start_q;
  logic write_start_q;
  logic write_enable_q;
  logic write_error_q;
  logic erase_sel_q;
  logic latch_only_q;
  logic cfg_space_q;
  logic op_go_q;
  logic [7:0] rdata_q;
  logic acc_wr;
  logic acc_rd;
  logic ctl_wr;
  logic start_wr;
  logic start_rd;
  logic stall_op;
  logic timer_load;
  logic timer_done;

  // =====================================================================
  // access decode
  function automatic logic hit(input logic [2:0] idx, input logic [2:0] want);
    hit = (idx == want);
  endfunction : hit

  // accesses in a held slot are not instructions and are dropped
  assign acc_wr = core.sfr_wr && !core.core_hold;
  assign acc_rd = core.sfr_rd && !core.core_hold;
  assign ctl_wr = acc_wr && hit(core.sfr_idx, SFR_CONTROL);
  assign start_wr = ctl_wr && (state_q == ST_IDLE) && core.sfr_wdata[CTL_WRITE_START];
  assign start_rd = ctl_wr && (state_q == ST_IDLE) && core.sfr_wdata[CTL_READ_START] && !start_wr;
  assign stall_op = erase_sel_q || !latch_only_q;

  // =====================================================================
  // sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_wr) begin
          state_d = ST_WR_PREP1;
        end else if (start_rd) begin
          state_d = ST_RD_SLOT1;
        end
      end
      ST_RD_SLOT1: state_d = ST_RD_ACCESS;
      ST_RD_ACCESS: state_d = ST_IDLE;
      ST_WR_PREP1: state_d = ST_WR_PREP2;
      ST_WR_PREP2: state_d = (op_go_q && stall_op) ? ST_WR_STALL : ST_IDLE;
      ST_WR_STALL: state_d = timer_done ? ST_IDLE : ST_WR_STALL;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || power_on_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // only the instruction slot is held; clocks and this logic keep running
  assign core.core_hold = (state_q == ST_RD_ACCESS) || (state_q == ST_WR_PREP1) ||
                          (state_q == ST_WR_PREP2) || (state_q == ST_WR_STALL);
  assign exec_stall_o = (state_q == ST_WR_STALL);

  // =====================================================================
  // unlock tracking
  always_ff @(posedge clk_i) begin
    if (rst_i || power_on_i) begin
      key_q <= KEY_NONE;
    end else if (start_wr) begin
      key_q <= KEY_NONE;
    end else if (acc_wr && hit(core.sfr_idx, SFR_UNLOCK)) begin
      if (core.sfr_wdata == UNLOCK_KEY_FIRST) begin
        key_q <= KEY_FIRST_SEEN;
      end else if (core.sfr_wdata == UNLOCK_KEY_SECOND && key_q == KEY_FIRST_SEEN) begin
        key_q <= KEY_ARMED;
      end else begin
        key_q <= KEY_NONE;
      end
    end
  end

  // armed and enabled decided at the start write itself
  always_ff @(posedge clk_i) begin
    if (rst_i || power_on_i) begin
      op_go_q <= 1'b0;
    end else if (start_wr) begin
      op_go_q <= core.sfr_wdata[CTL_WRITE_ENABLE] && (key_q == KEY_ARMED);
    end
  end

  // =====================================================================
  // control register
  always_ff @(posedge clk_i) begin
    if (rst_i || power_on_i) begin
      write_enable_q <= 1'b0;
      erase_sel_q <= 1'b0;
      latch_only_q <= 1'b0;
      cfg_space_q <= 1'b0;
    end else if (ctl_wr) begin
      write_enable_q <= core.sfr_wdata[CTL_WRITE_ENABLE];
      erase_sel_q <= core.sfr_wdata[CTL_ERASE_SEL];
      latch_only_q <= core.sfr_wdata[CTL_LATCH_ONLY];
      cfg_space_q <= core.sfr_wdata[CTL_CFG_SPACE];
    end
  end

  // software can only set the start bits; clear comes from completion
  always_ff @(posedge clk_i) begin
    if (rst_i || power_on_i) begin
      read_start_q <= 1'b0;
    end else if (start_rd) begin
      read_start_q <= 1'b1;
    end else if (state_q == ST_RD_ACCESS) begin
      read_start_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || power_on_i) begin
      write_start_q <= 1'b0;
    end else if (start_wr) begin
      write_start_q <= 1'b1;
    end else if (state_q != ST_IDLE && state_d == ST_IDLE && !read_start_q) begin
      write_start_q <= 1'b0;
    end
  end

  // a plain reset mid-operation leaves the error mark behind; power-on wipes it
  always_ff @(posedge clk_i) begin
    if (power_on_i) begin
      write_error_q <= 1'b0;
    end else if (rst_i) begin
      write_error_q <= write_error_q || (write_start_q && op_go_q);
    end else if (ctl_wr) begin
      write_error_q <= core.sfr_wdata[CTL_WRITE_ERROR];
    end
  end

  // =====================================================================
  // address and data pair
  always_ff @(posedge clk_i) begin
    if (rst_i || power_on_i) begin
      addr_low_q <= 8'h00;
      addr_high_q <= 7'h00;
    end else if (acc_wr && hit(core.sfr_idx, SFR_ADDR_LOW)) begin
      addr_low_q <= core.sfr_wdata;
    end else if (acc_wr && hit(core.sfr_idx, SFR_ADDR_HIGH)) begin
      addr_high_q <= core.sfr_wdata[6:0];
    end
  end

  // read completion cannot meet a software write: that slot is held
  always_ff @(posedge clk_i) begin
    if (rst_i || power_on_i) begin
      data_low_q <= 8'h00;
      data_high_q <= 6'h00;
    end else if (state_q == ST_RD_ACCESS) begin
      data_low_q <= flash_rdata_i[7:0];
      data_high_q <= flash_rdata_i[DATA_W-1:8];
    end else if (acc_wr && hit(core.sfr_idx, SFR_DATA_LOW)) begin
      data_low_q <= core.sfr_wdata;
    end else if (acc_wr && hit(core.sfr_idx, SFR_DATA_HIGH)) begin
      data_high_q <= core.sfr_wdata[5:0];
    end
  end

  // =====================================================================
  // read back, answered one cycle after the access
  function automatic logic [7:0] sfr_read(input logic [2:0] idx);
    unique case (idx)
      SFR_ADDR_LOW: sfr_read = addr_low_q;
      SFR_ADDR_HIGH: sfr_read = {1'b0, addr_high_q};
      SFR_DATA_LOW: sfr_read = data_low_q;
      SFR_DATA_HIGH: sfr_read = {2'b00, data_high_q};
      SFR_CONTROL: sfr_read = {1'b0, cfg_space_q, latch_only_q, erase_sel_q, write_error_q,
                               write_enable_q, write_start_q, read_start_q};
      default: sfr_read = 8'h00;
    endcase
  endfunction : sfr_read

  always_ff @(posedge clk_i) begin
    if (rst_i || power_on_i) begin
      rdata_q <= 8'h00;
    end else if (acc_rd) begin
      rdata_q <= sfr_read(core.sfr_idx);
    end
  end
  assign core.sfr_rdata = rdata_q;

  // =====================================================================
  // flash array strobes
  assign flash_addr_o = {addr_high_q, addr_low_q};
  assign flash_row_o = flash_addr_o[ADDR_W-1:ROW_LSB];
  assign flash_cfg_space_o = cfg_space_q;
  assign flash_wdata_o = {data_high_q, data_low_q};
  assign flash_rd_o = (state_q == ST_RD_ACCESS);
  assign flash_erase_o = (state_q == ST_WR_PREP2) && op_go_q && erase_sel_q;
  assign flash_load_o = (state_q == ST_WR_PREP2) && op_go_q && !erase_sel_q && latch_only_q;
  assign flash_prog_o = (state_q == ST_WR_PREP2) && op_go_q && !erase_sel_q && !latch_only_q;
  assign timer_load = (state_q == ST_WR_PREP2) && op_go_q && stall_op;

  stall_timer #(
    .CYCLES(STALL_CYCLES)
  ) u_stall_timer (
    .clk_i(clk_i),
    .rst_i(rst_i || power_on_i),
    .load_i(timer_load),
    .done_o(timer_done)
  );
endmodule : flash_ctrl_end

//--- src/flash_sfr_if.sv
interface flash_sfr_if;
  logic sfr_wr;
  logic sfr_rd;
  logic [2:0] sfr_idx;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic core_hold;

  modport core (
    output sfr_wr,
    output sfr_rd,
    output sfr_idx,
    output sfr_wdata,
    input sfr_rdata,
    input core_hold
  );

  modport ctrl (
    input sfr_wr,
    input sfr_rd,
    input sfr_idx,
    input sfr_wdata,
    output sfr_rdata,
    output core_hold
  );
endinterface : flash_sfr_if

//--- src/fsp_pkg.sv
package fsp_pkg;

  // =====================================================================
  // widths
  localparam int ADDR_W = 15;
  localparam int DATA_W = 14;
  localparam int ROW_LSB = 5;
  localparam int ROW_W = ADDR_W - ROW_LSB;

  // =====================================================================
  // special function register indices on the core side
  localparam logic [2:0] SFR_ADDR_LOW = 3'h0;
  localparam logic [2:0] SFR_ADDR_HIGH = 3'h1;
  localparam logic [2:0] SFR_DATA_LOW = 3'h2;
  localparam logic [2:0] SFR_DATA_HIGH = 3'h3;
  localparam logic [2:0] SFR_CONTROL = 3'h4;
  localparam logic [2:0] SFR_UNLOCK = 3'h5;

  // =====================================================================
  // flash_control_reg bit positions
  localparam int CTL_READ_START = 0;
  localparam int CTL_WRITE_START = 1;
  localparam int CTL_WRITE_ENABLE = 2;
  localparam int CTL_WRITE_ERROR = 3;
  localparam int CTL_ERASE_SEL = 4;
  localparam int CTL_LATCH_ONLY = 5;
  localparam int CTL_CFG_SPACE = 6;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // =====================================================================
  // unlock keys
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;

  // =====================================================================
  // timing
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int ERASE_TIME_US = 2000;
  localparam int ERASE_CYCLES = (ERASE_TIME_US * CLK_FREQ_KHZ) / 1000;
  localparam int TIMER_W = 16;

  // =====================================================================
  // host APB register map
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_RDATA = 8'h08;
  localparam logic [7:0] APB_IRQCTL = 8'h0c;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_READ_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int IRQ_GIE_BIT = 0;

  // =====================================================================
  // controller sequence
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_SLOT1,
    ST_RD_ACCESS,
    ST_WR_PREP1,
    ST_WR_PREP2,
    ST_WR_STALL
  } seq_state_t;

  typedef enum logic [1:0] {
    KEY_NONE,
    KEY_FIRST_SEEN,
    KEY_ARMED
  } key_stage_t;

endpackage : fsp_pkg

//--- src/sfr_core_end.sv
module sfr_core_end (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // controller side
  flash_sfr_if.core ctl,
  // core status
  output logic global_irq_enable_o
);
  import fsp_pkg::*;

  logic pend_q;
  logic wait_q;
  logic is_read_q;
  logic [2:0] idx_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic gie_q;
  logic apb_acc;
  logic cmd_hit;
  logic busy;
  logic issue;
  logic mapped;

  // =====================================================================
  // apb decode
  assign apb_acc = psel_i && penable_i;
  assign cmd_hit = (paddr_i == APB_CMD);
  assign busy = pend_q || wait_q;
  // a new order waits in the access phase until the last one is done
  assign pready_o = !(pwrite_i && cmd_hit && busy);
  assign mapped = cmd_hit || (paddr_i == APB_STATUS) || (paddr_i == APB_RDATA) ||
                  (paddr_i == APB_IRQCTL);
  assign pslverr_o = apb_acc && !mapped;

  always_comb begin
    prdata_o = 32'h0000_0000;
    unique case (paddr_i)
      APB_CMD: prdata_o = {15'h0000, is_read_q, 5'h00, idx_q, wdata_q};
      APB_STATUS: prdata_o = {30'h0000_0000, ctl.core_hold, busy};
      APB_RDATA: prdata_o = {24'h00_0000, rdata_q};
      APB_IRQCTL: prdata_o = {31'h0000_0000, gie_q};
      default: prdata_o = 32'h0000_0000;
    endcase
  end

  // =====================================================================
  // order register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q <= 3'h0;
      wdata_q <= 8'h00;
      is_read_q <= 1'b0;
    end else if (apb_acc && pready_o && pwrite_i && cmd_hit) begin
      idx_q <= pwdata_i[CMD_IDX_LSB +: 3];
      wdata_q <= pwdata_i[CMD_DATA_LSB +: 8];
      is_read_q <= pwdata_i[CMD_READ_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gie_q <= 1'b0;
    end else if (apb_acc && pwrite_i && (paddr_i == APB_IRQCTL)) begin
      gie_q <= pwdata_i[IRQ_GIE_BIT];
    end
  end
  assign global_irq_enable_o = gie_q;

  // =====================================================================
  // instruction slot: nothing issues while the controller holds the core
  assign issue = pend_q && !ctl.core_hold;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else if (apb_acc && pready_o && pwrite_i && cmd_hit) begin
      pend_q <= 1'b1;
    end else if (issue) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (issue && is_read_q) begin
      wait_q <= 1'b1;
    end else if (wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= ctl.sfr_rdata;
    end
  end

  assign ctl.sfr_wr = issue && !is_read_q;
  assign ctl.sfr_rd = issue && is_read_q;
  assign ctl.sfr_idx = idx_q;
  assign ctl.sfr_wdata = wdata_q;
endmodule : sfr_core_end

//--- src/stall_timer.sv
module stall_timer #(
  parameter int CYCLES = fsp_pkg::ERASE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  output logic done_o
);
  import fsp_pkg::*;

  logic [TIMER_W-1:0] count_q;

  // =====================================================================
  // countdown; done in the last counted cycle so the stall is exactly CYCLES
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else if (load_i) begin
      count_q <= TIMER_W'(CYCLES);
    end else if (count_q != '0) begin
      count_q <= count_q - TIMER_W'(1);
    end
  end

  assign done_o = (count_q == TIMER_W'(1));
endmodule : stall_timer

//--- verification/flash_self_program_read_erase_test.sv
module flash_self_program_read_erase_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fsp_pkg::*;
  localparam int STALL = 20;
  logic clk_i, rst_i, power_on_i, psel, penable, pwrite, pready, pslverr, global_irq_enable, e;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, r;
  logic [14:0] f_addr;
  logic [13:0] f_rdata, f_wdata, wd_seen, w;
  logic [9:0] f_row, row_seen;
  logic f_rd, f_erase, f_load, f_prog, f_stall, f_cfg;
  int n_errors, tests_run, n_rd, n_erase, n_load, n_prog, n_stall;

  // =====================================
  // design
  flash_sfr_if sfr_bus ();
  sfr_core_end u_sfr_core_end (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ctl(sfr_bus), .global_irq_enable_o(global_irq_enable));
  flash_ctrl_end #(.STALL_CYCLES(STALL)) u_flash_ctrl_end (.clk_i(clk_i), .rst_i(rst_i),
    .power_on_i(power_on_i), .core(sfr_bus), .flash_addr_o(f_addr), .flash_cfg_space_o(f_cfg),
    .flash_rd_o(f_rd), .flash_rdata_i(f_rdata), .flash_row_o(f_row), .flash_erase_o(f_erase),
    .flash_wdata_o(f_wdata), .flash_load_o(f_load), .flash_prog_o(f_prog), .exec_stall_o(f_stall));
  flash_sfr_props #(.STALL_CYCLES(STALL)) chk (.clk_i(clk_i), .rst_i(rst_i), .sfr_wr(sfr_bus.sfr_wr),
    .sfr_rd(sfr_bus.sfr_rd), .sfr_idx(sfr_bus.sfr_idx), .sfr_wdata(sfr_bus.sfr_wdata),
    .sfr_rdata(sfr_bus.sfr_rdata), .core_hold(sfr_bus.core_hold));

  always #50 clk_i = ~clk_i;

  function automatic logic [13:0] mem_word(input logic [14:0] a);
    return a[13:0] ^ 14'h2a5a;
  endfunction : mem_word

  always @(posedge clk_i) f_rdata <= mem_word(f_addr);

  // watched mid-cycle so strobes are settled
  always @(negedge clk_i) begin
    if (f_rd === 1'b1) n_rd++;
    if (f_erase === 1'b1) begin
      n_erase++;
      row_seen = f_row;
    end
    if (f_load === 1'b1) begin
      n_load++;
      wd_seen = f_wdata;
    end
    if (f_prog === 1'b1) n_prog++;
    if (f_stall === 1'b1) n_stall++;
  end

  // =====================================
  // tasks
  task report_and_stop;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task check_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_byte

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  // answer taken at the rising edge where pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    logic ok;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
      ok = (pready === 1'b1);
      r = prdata;
      e = pslverr;
    end while (!ok && i < 400);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
    if (!ok) begin
      n_errors++;
      report_and_stop();
    end
  endtask : apb

  task wait_idle;
    int i;
    i = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      i++;
    end while (r[1:0] !== 2'b00 && i < 100);
    if (r[1:0] !== 2'b00) begin
      n_errors++;
      report_and_stop();
    end
  endtask : wait_idle

  task sfr_issue(input logic [2:0] idx, input logic [7:0] d);
    apb(1'b1, APB_CMD, {16'h0, 5'h0, idx, d});
  endtask : sfr_issue

  task sfr_write(input logic [2:0] idx, input logic [7:0] d);
    sfr_issue(idx, d);
    wait_idle();
  endtask : sfr_write

  task sfr_read(input logic [2:0] idx);
    apb(1'b1, APB_CMD, {15'h0, 1'b1, 5'h0, idx, 8'h00});
    wait_idle();
    apb(1'b0, APB_RDATA, 32'h0);
    b = r[7:0];
  endtask : sfr_read

  task unlock_start(input logic [7:0] ctl);
    sfr_write(SFR_UNLOCK, UNLOCK_KEY_FIRST);
    sfr_write(SFR_UNLOCK, UNLOCK_KEY_SECOND);
    sfr_write(SFR_CONTROL, ctl);
  endtask : unlock_start

  task do_reset(input logic por);
    rst_i <= 1'b1;
    power_on_i <= por;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    power_on_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  // =====================================
  // sequence
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    power_on_i = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    do_reset(1'b1);
    sfr_read(SFR_CONTROL);
    check_byte(b, CTL_RESET);
    sfr_write(SFR_CONTROL, 8'h40);
    check_byte({7'h0, f_cfg}, 8'h01);
    sfr_write(SFR_ADDR_HIGH, 8'hff);
    sfr_read(SFR_ADDR_HIGH);
    check_byte(b, 8'h7f);
    sfr_read(3'h6);
    check_byte(b, 8'h00);
    apb(1'b0, 8'h10, 32'h0);
    check_word({r[30:0], e}, 32'h1);
    sfr_write(SFR_ADDR_LOW, 8'h34);
    sfr_write(SFR_ADDR_HIGH, 8'h12);
    sfr_write(SFR_CONTROL, 8'h01);
    w = mem_word(15'h1234);
    sfr_read(SFR_DATA_LOW);
    check_byte(b, w[7:0]);
    sfr_read(SFR_DATA_HIGH);
    check_byte(b, {2'b00, w[13:8]});
    check_word(32'(n_rd), 32'd1);
    check_byte({7'h0, f_cfg}, 8'h00);
    sfr_read(SFR_CONTROL);
    check_byte(b, 8'h00);
    sfr_write(SFR_ADDR_LOW, 8'h99);
    sfr_read(SFR_DATA_LOW);
    check_byte(b, w[7:0]);
    sfr_write(SFR_DATA_LOW, 8'h77);
    sfr_read(SFR_DATA_LOW);
    check_byte(b, 8'h77);
    sfr_write(SFR_UNLOCK, UNLOCK_KEY_FIRST);
    sfr_read(SFR_UNLOCK);
    check_byte(b, 8'h00);
    apb(1'b1, APB_IRQCTL, 32'h0);
    check_byte({7'h0, global_irq_enable}, 8'h00);
    sfr_write(SFR_ADDR_LOW, 8'h3b);
    sfr_write(SFR_ADDR_HIGH, 8'h25);
    sfr_write(SFR_CONTROL, 8'h14);
    unlock_start(8'h16);
    check_word(32'(n_erase), 32'd1);
    check_word({22'h0, row_seen}, {22'h0, 10'(15'h253b >> ROW_LSB)});
    check_word(32'(n_stall), STALL);
    sfr_read(SFR_CONTROL);
    check_byte(b, 8'h14);
    apb(1'b1, APB_IRQCTL, 32'h1);
    check_byte({7'h0, global_irq_enable}, 8'h01);
    sfr_write(SFR_CONTROL, 8'h10);
    unlock_start(8'h12);
    check_word(32'(n_erase), 32'd1);
    sfr_write(SFR_UNLOCK, UNLOCK_KEY_FIRST);
    sfr_write(SFR_UNLOCK, 8'h00);
    sfr_write(SFR_UNLOCK, UNLOCK_KEY_SECOND);
    sfr_write(SFR_CONTROL, 8'h16);
    check_word(32'(n_erase), 32'd1);
    sfr_write(SFR_DATA_LOW, 8'hc3);
    sfr_write(SFR_DATA_HIGH, 8'h2d);
    sfr_write(SFR_CONTROL, 8'h24);
    unlock_start(8'h26);
    check_word({n_load[17:0], wd_seen}, {18'h1, 14'h2dc3});
    check_word(32'(n_stall), STALL);
    sfr_write(SFR_CONTROL, 8'h04);
    unlock_start(8'h06);
    check_word(32'(n_prog), 32'd1);
    check_word(32'(n_stall), 2 * STALL);
    sfr_write(SFR_CONTROL, 8'h14);
    sfr_write(SFR_UNLOCK, UNLOCK_KEY_FIRST);
    sfr_write(SFR_UNLOCK, UNLOCK_KEY_SECOND);
    sfr_issue(SFR_CONTROL, 8'h16);
    // lands inside the timed stall
    repeat (8) @(posedge clk_i);
    do_reset(1'b0);
    sfr_read(SFR_CONTROL);
    check_byte(b, 8'h08);
    do_reset(1'b1);
    sfr_read(SFR_CONTROL);
    check_byte(b, 8'h00);
    report_and_stop();
  end
endmodule : flash_self_program_read_erase_test

//--- verification/flash_sfr_props.sv
module flash_sfr_props #(
  parameter int STALL_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched interface
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [2:0] sfr_idx,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic core_hold
);
  timeunit 1ns;
  timeprecision 1ns;
  import fsp_pkg::*;
  logic wr_ok, rd_ok, st_new, wr_st, stall_go;
  logic prev_st_q, act_q;
  logic [15:0] cnt_q;
  key_stage_t key_q;

  // =====================================
  // helper logic
  assign wr_ok = sfr_wr && !core_hold;
  assign rd_ok = sfr_rd && !core_hold;
  // a start right behind another start lands outside idle and is ignored
  assign st_new = wr_ok && sfr_idx == SFR_CONTROL && !prev_st_q && (sfr_wdata[1:0] != 2'b00);
  assign wr_st = st_new && sfr_wdata[CTL_WRITE_START];
  // erase always stalls, even with latch-only set
  assign stall_go = wr_st && sfr_wdata[CTL_WRITE_ENABLE] && key_q == KEY_ARMED &&
                    (sfr_wdata[CTL_ERASE_SEL] || !sfr_wdata[CTL_LATCH_ONLY]);

  always_ff @(posedge clk_i) begin
    prev_st_q <= !rst_i && wr_ok && sfr_idx == SFR_CONTROL && (sfr_wdata[1:0] != 2'b00);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_q <= KEY_NONE;
    end else if (wr_ok && sfr_idx == SFR_UNLOCK) begin
      if (sfr_wdata == UNLOCK_KEY_FIRST) begin
        key_q <= KEY_FIRST_SEEN;
      end else if (sfr_wdata == UNLOCK_KEY_SECOND && key_q == KEY_FIRST_SEEN) begin
        key_q <= KEY_ARMED;
      end else begin
        key_q <= KEY_NONE;
      end
    end else if (wr_st) begin
      key_q <= KEY_NONE;
    end
  end

  // counts held slots from a timed start until release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (stall_go) begin
      act_q <= 1'b1;
      cnt_q <= 16'h0000;
    end else if (act_q && core_hold) begin
      cnt_q <= cnt_q + 16'h0001;
    end else begin
      act_q <= 1'b0;
    end
  end

  // =====================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_unlock_reads_zero: assert property (rd_ok && sfr_idx == SFR_UNLOCK |=> sfr_rdata == 8'h00)
    else $error("unlock register read not zero");
  a_unused_idx_zero: assert property (rd_ok && sfr_idx[2:1] == 2'b11 |=> sfr_rdata == 8'h00)
    else $error("unused index read not zero");
  a_rdata_holds: assert property (!rd_ok |=> $stable(sfr_rdata))
    else $error("read answer changed without a read");
  a_read_slot_lost: assert property (st_new && !sfr_wdata[CTL_WRITE_START]
    |=> !core_hold ##1 core_hold ##1 !core_hold)
    else $error("read did not take exactly the second slot");
  a_forced_two_nops: assert property (wr_st |=> core_hold [*2])
    else $error("write start did not force two nops");
  a_untimed_no_stall: assert property (wr_st && !stall_go |=> core_hold [*2] ##1 !core_hold)
    else $error("stall without an armed timed operation");
  a_stall_length: assert property (act_q && !core_hold |-> cnt_q == 16'(STALL_CYCLES + 2))
    else $error("stall length wrong");
  a_stall_bounded: assert property (stall_go |=> ##[2:1000] !core_hold)
    else $error("stall never ended");
  a_hold_has_cause: assert property ($rose(core_hold) |-> $past(wr_st) || $past(st_new, 2))
    else $error("hold rose without a start");
endmodule : flash_sfr_props
